// ---- core/acrc_params.svh ----
`ifndef ACRC_PARAMS_SVH
`define ACRC_PARAMS_SVH
`define ACRC_SEL_HI_BIT     7
`define ACRC_SEL_LO_BIT     6
`define ACRC_CONV_SEL_BIT   7
`define ACRC_TEMP_BIT       0
`define ACRC_CLK_MSB        5
`define ACRC_CLK_LSB        4
`define ACRC_REF_MSB        3
`define ACRC_REF_LSB        2
`define ACRC_PAIR_MSB       1
`define ACRC_PAIR_LSB       0
`define ACRC_SETUP_RST      6'h2A
`define ACRC_CLK_EXT        2'h3
`define ACRC_CLK_GATED      2'h1
`define ACRC_PAIR_BIPOLAR   2'h3
`define ACRC_WAKE_AIN       8'hDA
`define ACRC_WAKE_TEMP      8'hF4
`define ACRC_WAKE_FORCED    8'hBC
`define ACRC_BITS_LAST      3'h7
`endif

// ---- core/acrc_pkg.sv ----
package acrc_pkg;
  typedef struct packed {
    logic [1:0] clock_mode;
    logic [1:0] reference_mode;
    logic [1:0] pair_config;
  } acrc_setup_s;

  typedef enum logic [2:0] {
    ACRC_IDLE = 3'b001,
    ACRC_WAKE = 3'b010,
    ACRC_RUN  = 3'b100
  } acrc_seq_e;
endpackage

// ---- core/acrc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "acrc_params.svh"
module acrc_top (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       sdin_i,
  input  wire logic       convert_start_pin_i,
  input  wire logic       int_tick_i,
  input  wire logic       scan_done_i,
  input  wire logic       ref_force_on_i,
  output logic [1:0]      clock_mode_o,
  output logic [1:0]      reference_mode_o,
  output logic [1:0]      pair_config_o,
  output logic [7:0]      unipolar_o,
  output logic [7:0]      bipolar_o,
  output logic            start_pin_active_o,
  output logic            top_ain_enable_o,
  output logic            adc_ref_pin_is_ref_o,
  output logic            acq_pin_timed_o,
  output logic            conv_clk_external_o,
  output logic            int_ref_power_o,
  output logic            scan_busy_o,
  output logic            convert_go_o,
  output logic            temp_first_o
);
  // ---------------- link domain, bit counter and shift register cleared between frames by chip select
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [6:0] shift_q,   shift_d;
  logic [7:0] byte_q,    byte_d;
  logic       byte_tgl_q, byte_tgl_d;
  logic       edge_tgl_q, edge_tgl_d;

  always_comb begin
    bit_cnt_d  = bit_cnt_q + 3'h1;
    shift_d    = {shift_q[5:0], sdin_i};
    byte_d     = byte_q;
    byte_tgl_d = byte_tgl_q;
    edge_tgl_d = ~edge_tgl_q;
    if (bit_cnt_q == `ACRC_BITS_LAST) begin
      byte_d     = {shift_q, sdin_i};
      byte_tgl_d = ~byte_tgl_q;
    end
  end

  // partial bytes are dropped when chip select goes high
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_q  <= 3'h0;
      shift_q    <= 7'h00;
    end else begin
      bit_cnt_q  <= bit_cnt_d;
      shift_q    <= shift_d;
    end
  end

  // byte_q holds for eight link clocks, long enough for the toggle sync;
  // kept across chip select so a last byte still in the synchroniser
  // when the frame ends is not lost. the link clock stands still in
  // reset, so the system reset may clear this side asynchronously
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      byte_q     <= 8'h00;
      byte_tgl_q <= 1'b0;
      edge_tgl_q <= 1'b0;
    end else begin
      byte_q     <= byte_d;
      byte_tgl_q <= byte_tgl_d;
      edge_tgl_q <= edge_tgl_d;
    end
  end

  // ---------------- crossings into the system clock
  logic [1:0] cs_s_q, tgl_s_q, edg_s_q, cnv_s_q;
  logic       cs_s3_q, tgl_s3_q, edg_s3_q, cnv_s3_q;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cs_s_q   <= 2'h3;
      tgl_s_q  <= 2'h0;
      edg_s_q  <= 2'h0;
      cnv_s_q  <= 2'h3;
      cs_s3_q  <= 1'b1;
      tgl_s3_q <= 1'b0;
      edg_s3_q <= 1'b0;
      cnv_s3_q <= 1'b1;
    end else begin
      cs_s_q   <= {cs_s_q[0], cs_n_i};
      tgl_s_q  <= {tgl_s_q[0], byte_tgl_q};
      edg_s_q  <= {edg_s_q[0], edge_tgl_q};
      cnv_s_q  <= {cnv_s_q[0], convert_start_pin_i};
      cs_s3_q  <= cs_s_q[1];
      tgl_s3_q <= tgl_s_q[1];
      edg_s3_q <= edg_s_q[1];
      cnv_s3_q <= cnv_s_q[1];
    end
  end

  // a frame counts as ended once either chip-select stage shows it high;
  // only an armed pair byte cares, the toggles never fall back
  logic in_frame;
  logic byte_ev;
  logic ext_tick;
  logic pin_fall;
  assign in_frame = !cs_s_q[1] && !cs_s3_q;
  assign byte_ev  = tgl_s_q[1] != tgl_s3_q;
  assign ext_tick = edg_s_q[1] != edg_s3_q;
  assign pin_fall = cnv_s3_q && !cnv_s_q[1];

  // ---------------- command decode
  acrc_pkg::acrc_setup_s setup_q, setup_d;
  logic [7:0] uni_q, uni_d, bip_q, bip_d;
  logic       expect_q, expect_d;
  logic [1:0] pair_code_q, pair_code_d;
  logic       temp_req_q, temp_req_d;
  logic       scan_trig;

  always_comb begin
    setup_d     = setup_q;
    uni_d       = uni_q;
    bip_d       = bip_q;
    expect_d    = expect_q && in_frame;
    pair_code_d = pair_code_q;
    temp_req_d  = temp_req_q;
    scan_trig   = 1'b0;
    if (byte_ev) begin
      if (expect_q) begin
        expect_d = 1'b0;
        if (pair_code_q == `ACRC_PAIR_BIPOLAR) begin
          bip_d = byte_q;
        end else begin
          uni_d = byte_q;
        end
      end else if (!byte_q[`ACRC_SEL_HI_BIT] &&
                   byte_q[`ACRC_SEL_LO_BIT]) begin
        setup_d.clock_mode     = byte_q[`ACRC_CLK_MSB:`ACRC_CLK_LSB];
        setup_d.reference_mode = byte_q[`ACRC_REF_MSB:`ACRC_REF_LSB];
        setup_d.pair_config    = byte_q[`ACRC_PAIR_MSB:`ACRC_PAIR_LSB];
        pair_code_d = byte_q[`ACRC_PAIR_MSB:`ACRC_PAIR_LSB];
        expect_d    = byte_q[`ACRC_PAIR_MSB];
      end else if (byte_q[`ACRC_CONV_SEL_BIT]) begin
        temp_req_d = byte_q[`ACRC_TEMP_BIT];
        scan_trig  = setup_q.clock_mode[1];
      end
    end
    if (pin_fall && !setup_q.clock_mode[1]) begin
      scan_trig = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      setup_q     <= `ACRC_SETUP_RST;
      uni_q       <= 8'h00;
      bip_q       <= 8'h00;
      expect_q    <= 1'b0;
      pair_code_q <= 2'h0;
      temp_req_q  <= 1'b0;
    end else begin
      setup_q     <= setup_d;
      uni_q       <= uni_d;
      bip_q       <= bip_d;
      expect_q    <= expect_d;
      pair_code_q <= pair_code_d;
      temp_req_q  <= temp_req_d;
    end
  end

  // ---------------- reference wake-up sequencer
  acrc_pkg::acrc_seq_e st_q, st_d;
  logic [7:0] wait_q, wait_d;
  logic       ref_on_q, ref_on_d;
  logic       go_d, temp_d;
  logic       tick;
  logic       ext_ref;

  assign ext_ref = setup_q.reference_mode[0];
  assign tick    = (setup_q.clock_mode == `ACRC_CLK_EXT) ?
                   ext_tick : int_tick_i;

  always_comb begin
    st_d     = st_q;
    wait_d   = wait_q;
    ref_on_d = ref_on_q || ref_force_on_i;
    go_d     = 1'b0;
    temp_d   = temp_first_o;
    unique case (st_q)
      acrc_pkg::ACRC_IDLE: begin
        // next value: a conversion byte's own temperature bit must
        // govern the scan that the same byte starts
        if (scan_trig) begin
          temp_d = temp_req_d;
          if (temp_req_d && ref_force_on_i) begin
            wait_d = `ACRC_WAKE_FORCED;
            st_d   = acrc_pkg::ACRC_WAKE;
          end else if (temp_req_d) begin
            ref_on_d = 1'b1;
            wait_d   = `ACRC_WAKE_TEMP;
            st_d     = acrc_pkg::ACRC_WAKE;
          end else if (ext_ref || ref_on_q) begin
            go_d = 1'b1;
            st_d = acrc_pkg::ACRC_RUN;
          end else begin
            ref_on_d = 1'b1;
            wait_d   = `ACRC_WAKE_AIN;
            st_d     = acrc_pkg::ACRC_WAKE;
          end
        end
      end
      acrc_pkg::ACRC_WAKE: begin
        if (tick) begin
          wait_d = wait_q - 8'h01;
          if (wait_q == 8'h01) begin
            go_d = 1'b1;
            st_d = acrc_pkg::ACRC_RUN;
          end
        end
      end
      acrc_pkg::ACRC_RUN: begin
        if (scan_done_i) begin
          st_d     = acrc_pkg::ACRC_IDLE;
          ref_on_d = ref_force_on_i;
        end
      end
      default: begin
        st_d = acrc_pkg::ACRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st_q         <= acrc_pkg::ACRC_IDLE;
      wait_q       <= 8'h00;
      ref_on_q     <= 1'b0;
      convert_go_o <= 1'b0;
      temp_first_o <= 1'b0;
    end else begin
      st_q         <= st_d;
      wait_q       <= wait_d;
      ref_on_q     <= ref_on_d;
      convert_go_o <= go_d;
      temp_first_o <= temp_d;
    end
  end

  // ---------------- registered mode outputs, one cycle behind setup; reference power and busy from next state
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      clock_mode_o         <= 2'h2;
      reference_mode_o     <= 2'h2;
      pair_config_o        <= 2'h0;
      unipolar_o           <= 8'h00;
      bipolar_o            <= 8'h00;
      start_pin_active_o   <= 1'b0;
      top_ain_enable_o     <= 1'b1;
      adc_ref_pin_is_ref_o <= 1'b0;
      acq_pin_timed_o      <= 1'b0;
      conv_clk_external_o  <= 1'b0;
      int_ref_power_o      <= 1'b0;
      scan_busy_o          <= 1'b0;
    end else begin
      clock_mode_o         <= setup_q.clock_mode;
      reference_mode_o     <= setup_q.reference_mode;
      pair_config_o        <= setup_q.pair_config;
      unipolar_o           <= uni_q;
      bipolar_o            <= bip_q;
      start_pin_active_o   <= !setup_q.clock_mode[1];
      top_ain_enable_o     <= setup_q.clock_mode[1];
      adc_ref_pin_is_ref_o <= ext_ref;
      acq_pin_timed_o      <= setup_q.clock_mode == `ACRC_CLK_GATED;
      conv_clk_external_o  <= setup_q.clock_mode == `ACRC_CLK_EXT;
      // taken from next state so busy already stands with the go pulse
      int_ref_power_o      <= ref_on_d;
      scan_busy_o          <= st_d != acrc_pkg::ACRC_IDLE;
    end
  end
endmodule // acrc_top
`default_nettype wire

// ---- bench/acrc_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module acrc_top_sva (
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  input wire logic       int_tick_i,
  input wire logic       scan_done_i,
  input wire logic       ref_force_on_i,
  input wire logic [1:0] clock_mode_o,
  input wire logic [1:0] reference_mode_o,
  input wire logic       start_pin_active_o,
  input wire logic       top_ain_enable_o,
  input wire logic       adc_ref_pin_is_ref_o,
  input wire logic       conv_clk_external_o,
  input wire logic       int_ref_power_o,
  input wire logic       scan_busy_o,
  input wire logic       convert_go_o,
  input wire logic       temp_first_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [8:0] wake_q;
  logic [8:0] wake_d;
  // ticks after the go pulse are not part of the wait
  always_comb begin
    wake_d = scan_busy_o ? wake_q : 9'h000;
    if (scan_busy_o && int_tick_i && !convert_go_o) wake_d = wake_q + 9'h001;
  end
  always_ff @(posedge sys_clk_i) wake_q <= rstn_i ? wake_d : 9'h000;
  chk_reset_modes: assert property (
    $rose(rstn_i) |-> clock_mode_o == 2'h2 && reference_mode_o == 2'h2)
    else $error("mode outputs wrong after reset");
  chk_shared_pin: assert property (
    start_pin_active_o == !clock_mode_o[1] && top_ain_enable_o == clock_mode_o[1])
    else $error("shared pin role does not follow clock mode");
  chk_ref_pin_role: assert property (
    adc_ref_pin_is_ref_o == reference_mode_o[0])
    else $error("second reference pin role wrong");
  chk_go_single: assert property (
    convert_go_o |-> scan_busy_o ##1 !convert_go_o)
    else $error("go pulse outside scan or too long");
  chk_ref_sleep: assert property (
    scan_done_i && scan_busy_o && !convert_go_o && !ref_force_on_i
    |=> !scan_busy_o && !int_ref_power_o) else $error("reference left on");
  chk_ext_ref_off: assert property (
    scan_busy_o && reference_mode_o[0] && !temp_first_o && !ref_force_on_i
    |-> !int_ref_power_o) else $error("reference powered for external mode");
  chk_temp_wait: assert property (
    convert_go_o && temp_first_o && !conv_clk_external_o
    |-> wake_q == (ref_force_on_i ? 9'h0BC : 9'h0F4)) else $error("temp wait");
  chk_ain_wait: assert property (
    convert_go_o && !temp_first_o && !conv_clk_external_o
    |-> wake_q inside {9'h000, 9'h0DA}) else $error("input wait wrong");
endmodule // acrc_top_sva
bind acrc_top acrc_top_sva u_sva (.*);
`default_nettype wire

// ---- bench/acrc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module acrc_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdin_o
);
  // chip select rises after time zero so the asynchronous clear fires
  initial begin
    {sclk_o, cs_n_o, sdin_o} = 3'b000;
    #1 cs_n_o = 1'b1;
  end
  // msb first; link clock stands still outside frames
  // never times a scan in clock mode 11, where it must be slow
  task automatic send(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      sdin_o = b[i];
      #7.5 sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
    end
    sdin_o = ~sdin_o; // released line never shows the last bit
  endtask
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1,
                       input logic two, input int n);
    cs_n_o = 1'b0;
    #10 send(b0, n);
    if (two) send(b1, 8);
    #10 cs_n_o = 1'b1;
    #100;
  endtask
endmodule // acrc_host_model
`default_nettype wire

// ---- bench/test_adc_setup_clock_ref_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_adc_setup_clock_ref_control;
  logic       sys_clk_i = 1'b0, rstn_i = 1'b1, sclk_i, cs_n_i, sdin_i;
  logic       convert_start_pin_i = 1'b1, int_tick_i = 1'b0;
  logic       scan_done_i = 1'b0, ref_force_on_i = 1'b0;
  logic [1:0] clock_mode_o, reference_mode_o, pair_config_o;
  logic [7:0] unipolar_o, bipolar_o;
  logic       start_pin_active_o, top_ain_enable_o, adc_ref_pin_is_ref_o;
  logic       acq_pin_timed_o, conv_clk_external_o, int_ref_power_o;
  logic       scan_busy_o, convert_go_o, temp_first_o;
  int         n_fail = 0, compares = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  acrc_host_model host_u (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdin_o(sdin_i));
  acrc_top dut_u (.*);
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) n_fail++;
    if (seen !== exp) $display("ERROR %0t seen %h expected %h", $time, seen, exp);
  endtask
  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] b0, input logic [7:0] b1,
                    input logic two, input int n);
    host_u.frame(b0, b1, two, n);
    repeat (4) @(negedge sys_clk_i);
  endtask
  function automatic logic [8:0] modes();
    return {5'h00, clock_mode_o, reference_mode_o};
  endfunction
  function automatic logic [8:0] flags();
    return {4'h0, start_pin_active_o, top_ain_enable_o, acq_pin_timed_o,
            conv_clk_external_o, adc_ref_pin_is_ref_o};
  endfunction
  task automatic t_reset();
    check(modes(), 9'h00A);
    check(flags(), 9'h008);
  endtask
  task automatic t_modes();
    logic [3:0] m;
    for (int i = 0; i < 16; i++) begin
      m = 4'(i);
      wr({2'h1, m, 1'b0, m[0]}, 8'h00, 1'b0, 8);
      check(modes(), {5'h00, m});
      check({7'h00, pair_config_o}, {8'h00, m[0]});
      check(flags(), {4'h0, !m[3], m[3], m[3:2] == 2'h1, m[3:2] == 2'h3,
                      m[0]});
    end
  endtask
  task automatic t_refuse();
    wr(8'h3F, 8'h00, 1'b0, 8);
    check(modes(), 9'h00F);
    wr(8'h40, 8'h00, 1'b0, 4);
    check(modes(), 9'h00F);
  endtask
  task automatic t_pair();
    wr(8'h6E, 8'hA5, 1'b1, 8);
    check({7'h00, pair_config_o}, 9'h002);
    check({1'b0, unipolar_o}, 9'h0A5);
    check({1'b0, bipolar_o}, 9'h000);
    wr(8'h6F, 8'h5A, 1'b1, 8);
    check({1'b0, bipolar_o}, 9'h05A);
    check(modes(), 9'h00B);
    wr(8'h69, 8'h00, 1'b0, 8);
    check({1'b0, unipolar_o}, 9'h0A5);
  endtask
  // ticks run only while busy so the count matches the wait exactly
  task automatic run_scan(input logic pin, input logic [7:0] cv, output int t);
    t = 0;
    convert_start_pin_i = !pin;
    fork
      if (!pin) host_u.frame(cv, 8'h00, 1'b0, 8);
    join_none
    repeat (1200) begin
      @(negedge sys_clk_i);
      convert_start_pin_i = 1'b1;
      if (convert_go_o === 1'b1) break;
      int_tick_i = scan_busy_o === 1'b1 && !int_tick_i;
      t += int'(int_tick_i);
    end
    int_tick_i = 1'b0;
    @(negedge sys_clk_i);
    scan_done_i = 1'b1;
    @(negedge sys_clk_i);
    scan_done_i = 1'b0;
    wait fork;
    @(negedge sys_clk_i);
  endtask
  task automatic t_scan();
    int t;
    wr(8'h40, 8'h00, 1'b0, 8);
    run_scan(1'b1, 8'h00, t);
    check(9'(t), 9'h0DA);
    check({7'h00, scan_busy_o, int_ref_power_o}, 9'h000);
    wr(8'h64, 8'h00, 1'b0, 8);
    run_scan(1'b0, 8'h80, t);
    check(9'(t), 9'h000);
    wr(8'h68, 8'h00, 1'b0, 8);
    run_scan(1'b0, 8'h81, t);
    check(9'(t), 9'h0F4);
    check({8'h00, int_ref_power_o}, 9'h000);
    ref_force_on_i = 1'b1;
    run_scan(1'b0, 8'h81, t);
    check(9'(t), 9'h0BC);
  endtask
  initial begin
    // a real falling edge, so the link-side clear is not missed
    #1 rstn_i = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    @(negedge sys_clk_i);
    t_reset();
    t_modes();
    t_refuse();
    t_pair();
    t_scan();
    report_and_stop();
  end
  initial begin
    #2000000;
    n_fail++;
    report_and_stop();
  end
endmodule // test_adc_setup_clock_ref_control
`default_nettype wire
